// ### hw/tmc_pkg.sv
// shared constants of the thermometer configuration link
package tmc_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_START_CONV = 8'h51;
  localparam logic [7:0] CMD_HALT_CONV = 8'h22;
  localparam logic [7:0] CMD_SW_RESET = 8'h54;
  localparam logic [7:0] CMD_CONFIG = 8'hac;
  // ----------------------------------------------------------------
  // slave address and control byte
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_FIXED = 4'h9;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // ----------------------------------------------------------------
  // control/status byte fields
  // ----------------------------------------------------------------
  localparam int BIT_DONE = 7;
  localparam int BIT_HI_FLAG = 6;
  localparam int BIT_LO_FLAG = 5;
  localparam int BIT_NV_BUSY = 4;
  localparam int BIT_RES_HI = 3;
  localparam int BIT_RES_LO = 2;
  localparam int BIT_POL = 1;
  localparam int BIT_SINGLE = 0;
  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] RES_RESET = 2'h3;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [1:0] NV_RESET = 2'h0;
  // ----------------------------------------------------------------
  // link framing counts
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
  // ----------------------------------------------------------------
  // master side: operations and clock divider
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_COMMAND = 2'h0;
  localparam logic [1:0] OP_CONFIG_WR = 2'h1;
  localparam logic [1:0] OP_CONFIG_RD = 2'h2;
  localparam int HOST_QUARTER_CYC = 4;
  localparam logic [2:0] QUARTER_LAST = 3'(HOST_QUARTER_CYC - 1);
endpackage

// ### hw/tmc_if.sv
// two-wire link between the bus master and the thermometer slave
`timescale 1ns/1ps
interface tmc_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;

  // open-drain wire with pull-up: any enabled low driver wins
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

// ### hw/tmc_sda_io.sv
// start/stop edge catcher and falling-edge data driver of the slave
`timescale 1ns/1ps
module tmc_sda_io (
  // link pins and reset
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_sys_rst,
  // drive request from the rising-edge logic
  input wire logic i_drive_low,
  // conditions and pin drive
  output logic o_start_tgl,
  output logic o_stop_tgl,
  output logic o_sda_o,
  output logic o_sda_oe
);
  // ----------------------------------------------------------------
  // conditions
  // ----------------------------------------------------------------
  // sda only moves with scl high at a start or stop, so its own edges
  // are the only clocks that can see them
  always_ff @(negedge i_sda or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_start_tgl <= 1'b0;
    end else if (i_scl) begin
      o_start_tgl <= ~o_start_tgl;
    end
  end

  always_ff @(posedge i_sda or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_stop_tgl <= 1'b0;
    end else if (i_scl) begin
      o_stop_tgl <= ~o_stop_tgl;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // data changes only while scl is low
  always_ff @(negedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sda_oe <= 1'b0;
      o_sda_o <= 1'b0;
    end else begin
      o_sda_oe <= i_drive_low;
      o_sda_o <= 1'b0;
    end
  end
endmodule

// ### hw/tmc_slave.sv
// thermometer end: two-wire slave and the control/status byte
`timescale 1ns/1ps
// Contract
// - eight-bit byte: done, flags, busy, resolution, polarity, mode
// - config command reads and writes the byte
// - master halts conversions before writing config
// - polarity and mode restored from nonvolatile image
// - done is read-only, low while converting
// - high flag sticks until cleared or reset
// - low flag sticks until cleared or reset
// - busy bit read-only, high during nonvolatile write
// - two resolution bits, both one at reset
// - polarity bit sets thermostat output active level
// - mode bit picks single or continuous conversion
// - slave only; open-drain data, clock input
// - both lines high means bus idle
// - data falling with clock high starts
// - data rising with clock high stops
// - repeated start begins a new transfer
// - receiver pulls data low for acknowledge
// - master not-acknowledges its last read byte
// - address is 1001 plus three select pins
// - control byte ends in direction bit
// - config command moves exactly one byte
// - msb first, eight bits plus acknowledge
// - software reset restores power-up state
module tmc_slave
  import tmc_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // two-wire link
  tmc_if.slave link,
  // address select straps
  input wire logic [2:0] i_addr_sel,
  // conversion engine and nonvolatile store status
  input wire logic i_conv_busy,
  input wire logic i_nv_busy,
  input wire logic i_temp_over_hi,
  input wire logic i_temp_under_lo,
  input wire logic i_trip_active,
  input wire logic [1:0] i_nv_image,
  // control toward the conversion engine
  output logic o_conv_start,
  output logic o_conv_halt,
  output logic o_soft_reset,
  output logic [1:0] o_resolution,
  output logic o_single_mode,
  // nonvolatile store update
  output logic o_nv_write,
  output logic [1:0] o_nv_image,
  // thermostat pin
  output logic o_tout
);
  // ----------------------------------------------------------------
  // link domain state (scl rising edge)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_CMD, L_DATA, L_TX, L_SKIP} tmc_link_st_t;

  typedef struct packed {
    tmc_link_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] txsh;
    logic [7:0] cmd;
    logic rd;
    logic start_seen;
    logic stop_seen;
    logic [2:0] addr_meta;
    logic [2:0] addr_sync;
    logic drive_low;
    logic ev_tgl;
    logic ev_wr;
    logic [7:0] ev_code;
    logic [7:0] ev_data;
  } tmc_link_t;

  // ----------------------------------------------------------------
  // core domain state (reference clock)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ev_meta;
    logic ev_sync;
    logic ev_seen;
    logic loaded;
    logic hi_flag;
    logic lo_flag;
    logic [1:0] res;
    logic output_polarity;
    logic single;
    logic [7:0] snap;
    logic conv_start;
    logic conv_halt;
    logic soft_reset;
    logic nv_write;
    logic [1:0] nv_image;
    logic tout;
  } tmc_core_t;

  tmc_link_t ln;
  tmc_link_t next_ln;
  tmc_core_t c;
  tmc_core_t next_c;
  logic start_tgl;
  logic stop_tgl;
  logic [7:0] sh;
  logic [3:0] cnt;
  logic [7:0] txs;
  logic [7:0] cfg;
  logic ev_now;

  tmc_sda_io tmc_sda_io_inst (
    .i_scl(link.scl),
    .i_sda(link.sda),
    .i_sys_rst(i_sys_rst),
    .i_drive_low(ln.drive_low),
    .o_start_tgl(start_tgl),
    .o_stop_tgl(stop_tgl),
    .o_sda_o(link.s_sda_o),
    .o_sda_oe(link.s_sda_oe)
  );

  // ----------------------------------------------------------------
  // link decoder
  // ----------------------------------------------------------------
  always_comb begin
    next_ln = ln;
    sh = {ln.shreg[6:0], link.sda};
    cnt = (ln.bitcnt == ACK_SLOT) ? 4'h1 : ln.bitcnt + 4'h1;
    txs = {ln.txsh[6:0], 1'b0};
    next_ln.addr_meta = i_addr_sel;
    next_ln.addr_sync = ln.addr_meta;
    if (start_tgl != ln.start_seen) begin
      next_ln.start_seen = start_tgl;
      next_ln.stop_seen = stop_tgl;
      next_ln.st = L_ADDR;
      next_ln.bitcnt = 4'h1;
      next_ln.shreg = sh;
      next_ln.drive_low = 1'b0;
    end else if (stop_tgl != ln.stop_seen) begin
      // stray clocks after a stop are ignored until the next start
      next_ln.stop_seen = stop_tgl;
      next_ln.st = L_IDLE;
      next_ln.drive_low = 1'b0;
    end else if (ln.st != L_IDLE) begin
      next_ln.bitcnt = cnt;
      next_ln.shreg = sh;
      next_ln.drive_low = 1'b0;
      case (ln.st)
        L_ADDR: begin
          if (cnt == BYTE_BITS) begin
            if (sh[7:4] == ADDR_FIXED && sh[3:1] == ln.addr_sync) begin
              next_ln.drive_low = 1'b1;
              next_ln.rd = (sh[0] == DIR_READ);
            end else begin
              next_ln.st = L_SKIP;
            end
          end else if (cnt == ACK_SLOT) begin
            if (ln.rd) begin
              next_ln.st = L_TX;
              next_ln.txsh = c.snap;
              next_ln.drive_low = ~c.snap[7];
            end else begin
              next_ln.st = L_CMD;
            end
          end
        end
        L_CMD: begin
          if (cnt == BYTE_BITS) begin
            next_ln.cmd = sh;
            next_ln.drive_low = 1'b1;
            next_ln.ev_tgl = ~ln.ev_tgl;
            next_ln.ev_wr = 1'b0;
            next_ln.ev_code = sh;
          end else if (cnt == ACK_SLOT) begin
            next_ln.st = (ln.cmd == CMD_CONFIG) ? L_DATA : L_SKIP;
          end
        end
        L_DATA: begin
          if (cnt == BYTE_BITS) begin
            next_ln.drive_low = 1'b1;
            next_ln.ev_tgl = ~ln.ev_tgl;
            next_ln.ev_wr = 1'b1;
            next_ln.ev_code = ln.cmd;
            next_ln.ev_data = sh;
          end else if (cnt == ACK_SLOT) begin
            next_ln.st = L_SKIP;
          end
        end
        L_TX: begin
          // released in the acknowledge slot so the master can answer
          if (cnt < BYTE_BITS) begin
            next_ln.txsh = txs;
            next_ln.drive_low = ~txs[7];
          end else if (cnt == ACK_SLOT) begin
            next_ln.st = L_SKIP;
          end
        end
        default: begin
          next_ln.drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link.scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ln <= '{st: L_IDLE, default: '0};
    end else begin
      ln <= next_ln;
    end
  end

  // ----------------------------------------------------------------
  // control/status byte
  // ----------------------------------------------------------------
  always_comb begin
    cfg = 8'h00;
    cfg[BIT_DONE] = ~i_conv_busy;
    cfg[BIT_HI_FLAG] = c.hi_flag;
    cfg[BIT_LO_FLAG] = c.lo_flag;
    cfg[BIT_NV_BUSY] = i_nv_busy;
    cfg[BIT_RES_HI] = c.res[1];
    cfg[BIT_RES_LO] = c.res[0];
    cfg[BIT_POL] = c.output_polarity;
    cfg[BIT_SINGLE] = c.single;
  end

  always_comb begin
    next_c = c;
    ev_now = c.ev_sync ^ c.ev_seen;
    next_c.ev_meta = ln.ev_tgl;
    next_c.ev_sync = c.ev_meta;
    next_c.ev_seen = c.ev_sync;
    next_c.conv_start = 1'b0;
    next_c.conv_halt = 1'b0;
    next_c.soft_reset = 1'b0;
    next_c.nv_write = 1'b0;
    if (!c.loaded) begin
      next_c.loaded = 1'b1;
      next_c.output_polarity = i_nv_image[1];
      next_c.single = i_nv_image[0];
    end
    if (ev_now) begin
      // word fields stay put in the link domain until the next byte
      next_c.snap = cfg;
      if (ln.ev_wr) begin
        // done and busy positions are never stored
        next_c.hi_flag = ln.ev_data[BIT_HI_FLAG];
        next_c.lo_flag = ln.ev_data[BIT_LO_FLAG];
        next_c.res = {ln.ev_data[BIT_RES_HI], ln.ev_data[BIT_RES_LO]};
        next_c.output_polarity = ln.ev_data[BIT_POL];
        next_c.single = ln.ev_data[BIT_SINGLE];
        next_c.nv_image = {ln.ev_data[BIT_POL], ln.ev_data[BIT_SINGLE]};
        next_c.nv_write = (ln.ev_data[BIT_POL] != c.output_polarity) ||
                          (ln.ev_data[BIT_SINGLE] != c.single);
      end else begin
        case (ln.ev_code)
          CMD_START_CONV: next_c.conv_start = 1'b1;
          CMD_HALT_CONV: next_c.conv_halt = 1'b1;
          CMD_SW_RESET: begin
            next_c.soft_reset = 1'b1;
            next_c.conv_halt = 1'b1;
            next_c.hi_flag = FLAG_RESET;
            next_c.lo_flag = FLAG_RESET;
            next_c.res = RES_RESET;
            next_c.loaded = 1'b0;
          end
          default: next_c.snap = cfg;
        endcase
      end
    end
    // a trip in the clearing cycle still lands
    if (i_temp_over_hi) begin
      next_c.hi_flag = 1'b1;
    end
    if (i_temp_under_lo) begin
      next_c.lo_flag = 1'b1;
    end
    next_c.tout = i_trip_active ? next_c.output_polarity : ~next_c.output_polarity;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      c <= '{res: RES_RESET, nv_image: NV_RESET, tout: 1'b1, default: '0};
    end else begin
      c <= next_c;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_conv_start = c.conv_start;
  assign o_conv_halt = c.conv_halt;
  assign o_soft_reset = c.soft_reset;
  assign o_resolution = c.res;
  assign o_single_mode = c.single;
  assign o_nv_write = c.nv_write;
  assign o_nv_image = c.nv_image;
  assign o_tout = c.tout;
endmodule

// ### hw/tmc_master.sv
// bus master end: drives scl and runs command, config write and read
`timescale 1ns/1ps
module tmc_master
  import tmc_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // two-wire link
  tmc_if.master link,
  // request
  input wire logic i_req,
  input wire logic [1:0] i_op,
  input wire logic [7:0] i_cmd,
  input wire logic [7:0] i_wdata,
  input wire logic [2:0] i_addr_sel,
  input wire logic i_halt_first,
  // answer
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic [7:0] o_rdata
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} tmc_host_st_t;

  typedef struct packed {
    tmc_host_st_t st;
    logic [2:0] qcnt;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [1:0] op;
    logic [7:0] cmd;
    logic [7:0] wdata;
    logic [2:0] addr;
    logic halting;
    logic rd_phase;
    logic [1:0] bidx;
    logic acked;
    logic scl;
    logic sda_oe;
    logic sda_meta;
    logic sda_sync;
    logic busy;
    logic done;
    logic nack;
    logic [7:0] rdata;
  } tmc_host_t;

  tmc_host_t h;
  tmc_host_t next_h;
  logic tick;
  logic [7:0] txb;

  function automatic logic [7:0] tx_byte(input logic [1:0] idx, input tmc_host_t s);
    logic [7:0] b;
    b = s.wdata;
    if (idx == 2'h0) begin
      b = {ADDR_FIXED, s.addr, s.rd_phase ? DIR_READ : DIR_WRITE};
    end else if (idx == 2'h1) begin
      b = s.halting ? CMD_HALT_CONV : ((s.op == OP_COMMAND) ? s.cmd : CMD_CONFIG);
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // sequencer: four quarters per scl period
  // ----------------------------------------------------------------
  always_comb begin
    next_h = h;
    txb = 8'h00;
    next_h.sda_meta = link.sda;
    next_h.sda_sync = h.sda_meta;
    next_h.done = 1'b0;
    tick = (h.qcnt == QUARTER_LAST);
    next_h.qcnt = tick ? 3'h0 : h.qcnt + 3'h1;
    if (h.st == H_IDLE) begin
      next_h.qcnt = 3'h0;
      next_h.q = 2'h0;
      if (i_req) begin
        next_h.st = H_START;
        next_h.op = i_op;
        next_h.cmd = i_cmd;
        next_h.wdata = i_wdata;
        next_h.addr = i_addr_sel;
        next_h.halting = (i_op == OP_CONFIG_WR) && i_halt_first;
        next_h.rd_phase = 1'b0;
        next_h.bidx = 2'h0;
        next_h.busy = 1'b1;
        next_h.nack = 1'b0;
      end
    end else if (tick) begin
      next_h.q = h.q + 2'h1;
      case (h.st)
        H_START: begin
          // sda moves a quarter after scl falls so no edge looks like a stop
          case (h.q)
            2'h0: next_h.scl = 1'b1;
            2'h1: next_h.sda_oe = 1'b1;
            2'h2: next_h.scl = 1'b0;
            default: begin
              txb = tx_byte(h.bidx, h);
              next_h.st = H_TX;
              next_h.sh = txb;
              next_h.bitn = 4'h0;
              next_h.sda_oe = ~txb[7];
            end
          endcase
        end
        H_TX, H_RX: begin
          case (h.q)
            2'h0: next_h.scl = 1'b1;
            2'h1: next_h.scl = 1'b1;
            2'h2: begin
              next_h.scl = 1'b0;
              if (h.bitn == BYTE_BITS) begin
                next_h.acked = ~h.sda_sync;
              end else if (h.st == H_RX) begin
                next_h.sh = {h.sh[6:0], h.sda_sync};
              end
            end
            default: begin
              if (h.bitn != BYTE_BITS) begin
                next_h.bitn = h.bitn + 4'h1;
                if (h.st == H_TX) begin
                  next_h.sh = {h.sh[6:0], 1'b0};
                end
                // released on the acknowledge slot; read answers with nack
                next_h.sda_oe = (h.st == H_TX) && (h.bitn != 4'h7) && ~h.sh[6];
              end else if (h.st == H_RX) begin
                next_h.rdata = h.sh;
                next_h.st = H_STOP;
              end else if (!h.acked) begin
                next_h.nack = 1'b1;
                next_h.st = H_STOP;
              end else if (h.bidx == 2'h0 && h.rd_phase) begin
                next_h.st = H_RX;
                next_h.bitn = 4'h0;
                next_h.sda_oe = 1'b0;
              end else if (h.bidx == 2'h0) begin
                txb = tx_byte(2'h1, h);
                next_h.bidx = 2'h1;
                next_h.sh = txb;
                next_h.bitn = 4'h0;
                next_h.sda_oe = ~txb[7];
              end else if (h.bidx == 2'h1 && !h.halting && h.op == OP_CONFIG_WR) begin
                txb = tx_byte(2'h2, h);
                next_h.bidx = 2'h2;
                next_h.sh = txb;
                next_h.bitn = 4'h0;
                next_h.sda_oe = ~txb[7];
              end else if (h.bidx == 2'h1 && !h.halting && h.op == OP_CONFIG_RD) begin
                next_h.st = H_START;
                next_h.rd_phase = 1'b1;
                next_h.bidx = 2'h0;
              end else begin
                next_h.st = H_STOP;
              end
            end
          endcase
        end
        H_STOP: begin
          case (h.q)
            2'h0: next_h.sda_oe = 1'b1;
            2'h1: next_h.scl = 1'b1;
            2'h2: next_h.sda_oe = 1'b0;
            default: begin
              if (h.halting && !h.nack) begin
                next_h.halting = 1'b0;
                next_h.bidx = 2'h0;
                next_h.st = H_START;
              end else begin
                next_h.st = H_IDLE;
                next_h.busy = 1'b0;
                next_h.done = 1'b1;
              end
            end
          endcase
        end
        default: next_h.st = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      h <= '{st: H_IDLE, scl: 1'b1, sda_meta: 1'b1, sda_sync: 1'b1, default: '0};
    end else begin
      h <= next_h;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.scl = h.scl;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe = h.sda_oe;
  assign o_busy = h.busy;
  assign o_done = h.done;
  assign o_nack = h.nack;
  assign o_rdata = h.rdata;
endmodule

// ### verif/tmc_link_props.sv
// wire-level checks on the two-wire carrier between master and thermometer
`timescale 1ns/1ps
module tmc_link_props (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // link signals
  input wire logic scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic sda
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  logic p_scl, p_sda, in_frame, rd;
  logic [3:0] cnt, bidx;
  wire start_ev = p_scl && scl && p_sda && !sda;
  wire stop_ev = p_scl && scl && !p_sda && sda;
  wire scl_rise = !p_scl && scl;
  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  // the set-up rise before a stop or repeated start is counted too
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      p_scl <= 1'b1;
      p_sda <= 1'b1;
      in_frame <= 1'b0;
      rd <= 1'b0;
      cnt <= 4'h0;
      bidx <= 4'h0;
    end else begin
      p_scl <= scl;
      p_sda <= sda;
      if (start_ev) begin
        in_frame <= 1'b1;
        cnt <= 4'h0;
        bidx <= 4'h0;
        rd <= 1'b0;
      end else if (stop_ev) begin
        in_frame <= 1'b0;
      end else if (scl_rise) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (cnt == 4'h8) bidx <= bidx + 4'h1;
        if (cnt == 4'h7 && bidx == 4'h0) rd <= sda;
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  open_drain_a: assert property ((s_sda_oe -> !s_sda_o) && (m_sda_oe -> !m_sda_o))
    else $error("data driven high by an end");
  stable_high_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave changed data with clock high");
  idle_quiet_a: assert property (!in_frame |-> !s_sda_oe)
    else $error("slave drives data outside a frame");
  start_fall_a: assert property (start_ev |-> ##[1:8] !scl)
    else $error("clock did not fall after start");
  whole_byte_a: assert property ((start_ev || stop_ev) && in_frame |-> cnt == 4'h1)
    else $error("frame condition inside a byte");
  nack_last_a: assert property (scl_rise && cnt == 4'h8 && rd && bidx == 4'h1 |-> sda)
    else $error("read byte not answered by nack");
  slave_quiet_a: assert property (scl_rise && cnt != 4'h8 && !(rd && bidx != 4'h0) |-> !s_sda_oe)
    else $error("slave drives while master transmits");
  ack_hold_a: assert property (scl_rise && cnt == 4'h8 && s_sda_oe |-> s_sda_oe [*7])
    else $error("acknowledge not held for the clock");
  cover property (start_ev && in_frame);
  cover property (scl_rise && cnt == 4'h8 && rd && bidx == 4'h1);
  cover property (stop_ev);
endmodule

// ### verif/tmc_bench.sv
// self-checking bench: master and thermometer ends joined by the link
`timescale 1ns/1ps
module thermometer_config_and_bus_slave_bench;
  import tmc_pkg::*;
  typedef struct packed {
    logic [1:0] op;
    logic [7:0] cmd;
    logic [7:0] wd;
    logic [2:0] adr;
    logic hf;
    logic nk;
    logic [7:0] rd;
  } tmc_row_t;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req = 1'b0, halt_first = 1'b0, busy, done, nack;
  logic [1:0] op = 2'h0;
  logic [7:0] cmd = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] maddr = 3'h5;
  logic conv_busy = 1'b0, nv_busy = 1'b0, over_hi = 1'b0, under_lo = 1'b0, trip = 1'b0;
  logic [1:0] nv_img = 2'h2, nv_img_o, resolution;
  logic conv_start, conv_halt, soft_reset, single_mode, nv_write, tout;
  int n_errors = 0, check_count = 0, cycles = 0, n_start = 0, n_nvw = 0;
  tmc_row_t rows [9];
  tmc_if link_if ();
  tmc_master tmc_master_inst (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .link(link_if.master),
    .i_req(req), .i_op(op), .i_cmd(cmd), .i_wdata(wdata), .i_addr_sel(maddr),
    .i_halt_first(halt_first), .o_busy(busy), .o_done(done), .o_nack(nack), .o_rdata(rdata));
  tmc_slave tmc_slave_inst (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .link(link_if.slave),
    .i_addr_sel(3'h5), .i_conv_busy(conv_busy), .i_nv_busy(nv_busy), .i_temp_over_hi(over_hi),
    .i_temp_under_lo(under_lo), .i_trip_active(trip), .i_nv_image(nv_img),
    .o_conv_start(conv_start), .o_conv_halt(conv_halt), .o_soft_reset(soft_reset),
    .o_resolution(resolution), .o_single_mode(single_mode), .o_nv_write(nv_write),
    .o_nv_image(nv_img_o), .o_tout(tout));
  tmc_link_props tmc_link_props_inst (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .scl(link_if.scl), .m_sda_o(link_if.m_sda_o), .m_sda_oe(link_if.m_sda_oe),
    .s_sda_o(link_if.s_sda_o), .s_sda_oe(link_if.s_sda_oe), .sda(link_if.sda));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (conv_start === 1'b1) n_start++;
    if (nv_write === 1'b1) n_nvw++;
    if (cycles == 30000) begin
      n_errors++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_byte(nm, {7'h00, e}, {7'h00, g});
  endtask
  // entered just after an edge; returns one step after the done edge
  task automatic xact(input logic [1:0] o, input logic [7:0] c, input logic [7:0] w,
                      input logic h);
    op = o;
    cmd = c;
    wdata = w;
    halt_first = h;
    req = 1'b1;
    @(posedge ref_clk);
    #1 req = 1'b0;
    for (int k = 0; k < 3000; k++) begin
      @(posedge ref_clk);
      #1;
      if (done === 1'b1) break;
    end
    if (done !== 1'b1) n_errors++;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{2'h2, 8'h00, 8'h00, 3'h5, 1'b0, 1'b0, 8'h8e},
             '{2'h1, 8'h00, 8'h01, 3'h5, 1'b1, 1'b0, 8'h00},
             '{2'h2, 8'h00, 8'h00, 3'h5, 1'b0, 1'b0, 8'h81},
             '{2'h1, 8'h00, 8'h1a, 3'h5, 1'b0, 1'b0, 8'h00},
             '{2'h2, 8'h00, 8'h00, 3'h5, 1'b0, 1'b0, 8'h8a},
             '{2'h1, 8'h00, 8'h00, 3'h2, 1'b0, 1'b1, 8'h00},
             '{2'h2, 8'h00, 8'h00, 3'h2, 1'b0, 1'b1, 8'h00},
             '{2'h2, 8'h00, 8'h00, 3'h5, 1'b0, 1'b0, 8'h8a},
             '{2'h0, 8'h51, 8'h00, 3'h5, 1'b0, 1'b0, 8'h00}};
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk_byte("resolution", 8'(RES_RESET), 8'(resolution));
    chk_bit("tout", 1'b0, tout);
    chk_bit("single", 1'b0, single_mode);
    foreach (rows[i]) begin
      maddr = rows[i].adr;
      xact(rows[i].op, rows[i].cmd, rows[i].wd, rows[i].hf);
      chk_bit("nack", rows[i].nk, nack);
      if (rows[i].op == OP_CONFIG_RD && !rows[i].nk) chk_byte("rdata", rows[i].rd, rdata);
      $display("row %0d done", i);
    end
    maddr = 3'h5;
    chk_byte("starts", 8'h01, 8'(n_start));
    chk_byte("nv writes", 8'h02, 8'(n_nvw));
    chk_byte("resolution", 8'h02, 8'(resolution));
    // status inputs and a one-cycle high trip
    conv_busy = 1'b1;
    nv_busy = 1'b1;
    trip = 1'b1;
    over_hi = 1'b1;
    @(posedge ref_clk);
    #1 over_hi = 1'b0;
    xact(OP_CONFIG_RD, 8'h00, 8'h00, 1'b0);
    chk_byte("status", 8'h5a, rdata);
    chk_bit("tout", 1'b1, tout);
    $display("status test done");
    // sticky flags cleared by writing zero, read-only bits untouched
    conv_busy = 1'b0;
    nv_busy = 1'b0;
    under_lo = 1'b1;
    @(posedge ref_clk);
    #1 under_lo = 1'b0;
    xact(OP_CONFIG_WR, 8'h00, 8'h1a, 1'b0);
    xact(OP_CONFIG_RD, 8'h00, 8'h00, 1'b0);
    chk_byte("cleared", 8'h8a, rdata);
    $display("flag clear test done");
    // software reset restores power-up values
    under_lo = 1'b1;
    @(posedge ref_clk);
    #1 under_lo = 1'b0;
    xact(OP_COMMAND, CMD_SW_RESET, 8'h00, 1'b0);
    xact(OP_CONFIG_RD, 8'h00, 8'h00, 1'b0);
    chk_byte("after reset", 8'h8e, rdata);
    $display("soft reset test done");
    test_done();
  end
endmodule
